// ==== logic/potm_trigger_ctrl.sv ====
// Trigger-select and output-mode registers of the pattern output unit,
// with the port output latch they steer. AXI4-Lite register slave.
// Assumes timer strobes, next-pattern data and enables on aclk.
`timescale 1ns/10ps

// Overview of operation
// - The 8-bit trigger-select register is read/write, loads all ones on reset or hardware standby and holds in software standby.
// - Each group of four pattern bits (15..12, 11..8, 7..4, 3..0) has its own trigger source.
// - Trigger-select bits 7:6 pick the timer channel 0 to 3 that loads group 3.
// - Trigger-select bits 5:4 pick the timer channel 0 to 3 that loads group 2.
// - Trigger-select bits 3:2 pick the timer channel 0 to 3 that loads group 1.
// - Trigger-select bits 1:0 pick the timer channel 0 to 3 that loads group 0.
// - The 8-bit output-mode register loads 0xf0 on reset or hardware standby and holds in software standby.
// - Output-mode bits 7:4 always read as one and ignore writes.
// - In non-overlap mode match B sets the period, match A the margin, and outputs change at both.
// - Output-mode bit 3 set makes group 3 non-overlapping, clear makes it change at match A only.
// - Output-mode bit 2 does the same for group 2.
// - Output-mode bit 1 does the same for group 1.
// - Output-mode bit 0 does the same for group 0.
// - On the selected trigger each enabled bit copies its next-pattern value, disabled bits hold.
// - In non-overlap mode match A copies the next-pattern bits unconditionally.
// - In non-overlap mode match B copies only next-pattern bits that are zero.
module potm_trigger_ctrl
	import potm_pkg::*;
#(
	parameter int CHANNELS = 4
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic hw_standby,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire potm_cm_t timer_match,
	input wire logic [PAT_W-1:0] next_pattern_reg,
	input wire logic [PAT_W-1:0] next_pattern_enable,
	input wire logic latch_wr_en,
	input wire logic [PAT_W-1:0] latch_wr_data,
	output logic [PAT_W-1:0] port_output_latch,
	output logic [REG_W-1:0] group_trigger_select,
	output logic [REG_W-1:0] group_output_mode
);

	////////////////////////////////////////////////////////////////////////
	// Elaboration check
	if (CHANNELS != CH_N) begin : g_bad_channels
		$error("Trigger select encodes exactly four timer channels");
	end

	////////////////////////////////////////////////////////////////////////
	// State
	potm_state_t state_reg;
	potm_state_t state_next;
	logic [PAT_W-1:0] upd;
	logic [GROUPS-1:0] hit_a;
	logic [GROUPS-1:0] hit_b;
	logic [PAT_W-1:0] sw_latch;

	////////////////////////////////////////////////////////////////////////
	// Per-group trigger and transfer logic
	for (genvar g = 0; g < GROUPS; g++) begin : g_grp
		potm_group u_grp (
			.sel(state_reg.trig_sel[g*SEL_W +: SEL_W]),
			.nov(state_reg.nov[g]),
			.cm(timer_match),
			.nxt(next_pattern_reg[g*GRP_W +: GRP_W]),
			.en(next_pattern_enable[g*GRP_W +: GRP_W]),
			.hit_a(hit_a[g]),
			.hit_b(hit_b[g]),
			.upd(upd[g*GRP_W +: GRP_W])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Bus handshakes
	assign s_axi_awready = !state_reg.aw_got && !state_reg.bvalid;
	assign s_axi_wready = !state_reg.w_got && !state_reg.bvalid;
	assign s_axi_arready = !state_reg.rvalid;
	assign s_axi_bvalid = state_reg.bvalid;
	assign s_axi_bresp = state_reg.bresp;
	assign s_axi_rvalid = state_reg.rvalid;
	assign s_axi_rdata = state_reg.rdata;
	assign s_axi_rresp = state_reg.rresp;

	////////////////////////////////////////////////////////////////////////
	// Register and latch outputs
	assign port_output_latch = state_reg.latch;
	assign group_trigger_select = state_reg.trig_sel;
	assign group_output_mode = {MODE_RSV_ONES, state_reg.nov};

	// Neighbour writes reach only bits not owned by pattern output
	assign sw_latch = latch_wr_en ?
		((state_reg.latch & next_pattern_enable) |
		(latch_wr_data & ~next_pattern_enable)) : state_reg.latch;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		state_next = state_reg;
		if (state_reg.bvalid && s_axi_bready) begin
			state_next.bvalid = 1'b0;
		end
		if (s_axi_awvalid && s_axi_awready) begin
			state_next.aw_got = 1'b1;
			state_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			state_next.w_got = 1'b1;
			state_next.w_data = s_axi_wdata;
			state_next.w_lane0 = s_axi_wstrb[0];
		end
		if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
			state_next.aw_got = 1'b0;
			state_next.w_got = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = RESP_OKAY;
			case (state_reg.aw_addr)
				TRIG_SEL_OFS: begin
					if (state_reg.w_lane0) begin
						state_next.trig_sel = state_reg.w_data[REG_W-1:0];
					end
				end
				OUT_MODE_OFS: begin
					if (state_reg.w_lane0) begin
						state_next.nov = state_reg.w_data[MODE_NOV_LSB +: GRP_W];
					end
				end
				default: begin
					state_next.bresp = RESP_SLVERR;
				end
			endcase
		end
		if (state_reg.rvalid && s_axi_rready) begin
			state_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			state_next.rvalid = 1'b1;
			state_next.rresp = RESP_OKAY;
			state_next.rdata = '0;
			case (s_axi_araddr)
				TRIG_SEL_OFS: begin
					state_next.rdata[REG_W-1:0] = state_reg.trig_sel;
				end
				OUT_MODE_OFS: begin
					state_next.rdata[REG_W-1:0] = {MODE_RSV_ONES, state_reg.nov};
				end
				default: begin
					state_next.rresp = RESP_SLVERR;
				end
			endcase
		end
		// Trigger transfer overrides the neighbour write on owned bits
		state_next.latch = (sw_latch & ~upd) | (next_pattern_reg & upd);
		if (!aresetn || hw_standby) begin
			state_next = '0;
			state_next.trig_sel = TRIG_SEL_RST;
			state_next.nov = OUT_MODE_RST[GRP_W-1:0];
			state_next.latch = LATCH_RST;
		end
	end

	always_ff @(posedge aclk) begin
		state_reg <= state_next;
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	property p_trig_rst;
		@(posedge aclk) disable iff (!aresetn)
		hw_standby |=> group_trigger_select == 8'hff;
	endproperty
	a_trig_rst: assert property (p_trig_rst)
		else $error("trigger select not all ones after standby");

	property p_mode_rst;
		@(posedge aclk) disable iff (!aresetn)
		hw_standby |=> group_output_mode == 8'hf0;
	endproperty
	a_mode_rst: assert property (p_mode_rst)
		else $error("output mode not f0 after standby");

	property p_mode_rsv;
		@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && s_axi_rresp == RESP_OKAY &&
		s_axi_rdata[REG_W-1:0] == {4'hf, state_reg.nov}
		|-> group_output_mode[7:4] == 4'hf;
	endproperty
	a_mode_rsv: assert property (p_mode_rsv)
		else $error("reserved mode bits not read as one");

	property p_trig_hold;
		@(posedge aclk) disable iff (!aresetn)
		!hw_standby && !(state_reg.aw_got && state_reg.w_got)
		|=> $stable(group_trigger_select) && $stable(group_output_mode);
	endproperty
	a_trig_hold: assert property (p_trig_hold)
		else $error("control register changed without a write");

	property p_g3_sel;
		@(posedge aclk) disable iff (!aresetn)
		hit_a[3] == timer_match.a[group_trigger_select[7:6]];
	endproperty
	a_g3_sel: assert property (p_g3_sel)
		else $error("group 3 uses the wrong timer channel");

	property p_g0_sel;
		@(posedge aclk) disable iff (!aresetn)
		hit_b[0] == timer_match.b[group_trigger_select[1:0]];
	endproperty
	a_g0_sel: assert property (p_g0_sel)
		else $error("group 0 uses the wrong timer channel");

	property p_disabled_hold;
		@(posedge aclk) disable iff (!aresetn || hw_standby)
		!latch_wr_en ##1 !hw_standby |->
		((port_output_latch ^ $past(port_output_latch)) &
		~$past(next_pattern_enable)) == '0;
	endproperty
	a_disabled_hold: assert property (p_disabled_hold)
		else $error("disabled pattern bit changed");

	property p_match_a_copy;
		@(posedge aclk) disable iff (!aresetn)
		hit_a[2] && next_pattern_enable[8] && !hw_standby
		|=> port_output_latch[8] == $past(next_pattern_reg[8]);
	endproperty
	a_match_a_copy: assert property (p_match_a_copy)
		else $error("match A did not copy next pattern");

	property p_nov_b_ones;
		@(posedge aclk) disable iff (!aresetn)
		state_reg.nov[1] && hit_b[1] && !hit_a[1] && !latch_wr_en &&
		next_pattern_reg[4] && !hw_standby
		|=> $stable(port_output_latch[4]);
	endproperty
	a_nov_b_ones: assert property (p_nov_b_ones)
		else $error("match B copied a one in non-overlap mode");

	property p_nov_b_zero;
		@(posedge aclk) disable iff (!aresetn)
		state_reg.nov[1] && hit_b[1] && next_pattern_enable[5] &&
		!next_pattern_reg[5] && !hw_standby
		|=> !port_output_latch[5];
	endproperty
	a_nov_b_zero: assert property (p_nov_b_zero)
		else $error("match B did not copy a zero");

	property p_norm_b;
		@(posedge aclk) disable iff (!aresetn)
		!state_reg.nov[3] && hit_b[3] && !hit_a[3] && !latch_wr_en &&
		!hw_standby
		|=> $stable(port_output_latch[15:12]);
	endproperty
	a_norm_b: assert property (p_norm_b)
		else $error("normal mode group changed on match B");

	property p_bresp_hold;
		@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready && !hw_standby
		|=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bresp_hold: assert property (p_bresp_hold)
		else $error("write response dropped before accepted");

	property p_write_resp;
		@(posedge aclk) disable iff (!aresetn)
		state_reg.aw_got && state_reg.w_got && !s_axi_bvalid &&
		!hw_standby |=> s_axi_bvalid;
	endproperty
	a_write_resp: assert property (p_write_resp)
		else $error("write response not raised one cycle after both");

endmodule : potm_trigger_ctrl

// ==== logic/potm_pkg.sv ====
// Shared constants and types for the pattern output trigger/mode block.
// Assumes a single system clock domain and an AXI4-Lite register bus.
package potm_pkg;

	localparam int GROUPS = 4;
	localparam int GRP_W = 4;
	localparam int PAT_W = 16;
	localparam int CH_N = 4;
	localparam int SEL_W = 2;
	localparam int REG_W = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	localparam logic [ADDR_W-1:0] TRIG_SEL_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] OUT_MODE_OFS = 8'h04;

	localparam logic [REG_W-1:0] TRIG_SEL_RST = 8'hff;
	localparam logic [REG_W-1:0] OUT_MODE_RST = 8'hf0;
	localparam logic [GRP_W-1:0] MODE_RSV_ONES = 4'hf;
	localparam int MODE_NOV_LSB = 0;
	localparam logic [PAT_W-1:0] LATCH_RST = 16'h0000;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Compare-match strobes from the timer unit, one bit per channel
	typedef struct packed {
		logic [CH_N-1:0] a;
		logic [CH_N-1:0] b;
	} potm_cm_t;

	// Complete state of the top module
	typedef struct packed {
		logic aw_got;
		logic [ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [DATA_W-1:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
		logic [REG_W-1:0] trig_sel;
		logic [GRP_W-1:0] nov;
		logic [PAT_W-1:0] latch;
	} potm_state_t;

endpackage : potm_pkg

// ==== logic/potm_group.sv ====
// Per-group trigger selection and transfer mask for four pattern bits.
// Assumes single-cycle compare-match strobes on the system clock.
`timescale 1ns/10ps

module potm_group
	import potm_pkg::*;
(
	input wire logic [SEL_W-1:0] sel,
	input wire logic nov,
	input wire potm_cm_t cm,
	input wire logic [GRP_W-1:0] nxt,
	input wire logic [GRP_W-1:0] en,
	output logic hit_a,
	output logic hit_b,
	output logic [GRP_W-1:0] upd
);

	////////////////////////////////////////////////////////////////////////
	// Channel select and transfer mask
	always_comb begin
		hit_a = cm.a[sel];
		hit_b = cm.b[sel];
		upd = '0;
		if (hit_a) begin
			upd = en;
		end
		if (nov && hit_b) begin
			upd = upd | (en & ~nxt);
		end
	end

endmodule : potm_group

// ==== verification/potm_timer_model.sv ====
// Timer unit model that issues compare-match strobes on request.
// Assumes the bench raises go for one cycle per wanted strobe set.
`timescale 1ns/10ps

module potm_timer_model
	import potm_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic go,
	input wire potm_cm_t pat,
	output potm_cm_t cm
);
	// One-cycle match A and B strobes per channel on aclk
	// Bench orders match A before match B in non-overlap mode
	always_ff @(posedge aclk) begin
		if (!aresetn)
			cm <= '0;
		else
			cm <= go ? pat : '0;
	end
endmodule : potm_timer_model

// ==== verification/test_potm_trigger_ctrl.sv ====
// Self-checking bench for the trigger-select and output-mode block.
// Assumes the timer model file and the design package are compiled first.
`timescale 1ns/10ps

module test_potm_trigger_ctrl
	import potm_pkg::*;
;
	logic aclk = 0, aresetn = 0, hw_standby = 0, tgo = 0, latch_wr_en = 0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_rvalid;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	potm_cm_t timer_match, tpat = '0;
	logic [PAT_W-1:0] next_pattern_reg = '0, next_pattern_enable = '0;
	logic [PAT_W-1:0] latch_wr_data = '0, port_output_latch;
	logic [PAT_W-1:0] exp_lat = LATCH_RST;
	logic [REG_W-1:0] group_trigger_select, group_output_mode;
	int fail_count = 0, total_checks = 0, cyc = 0;

	always #2 aclk = ~aclk;

	potm_trigger_ctrl i_potm_trigger_ctrl (.aclk, .aresetn, .hw_standby,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .timer_match, .next_pattern_reg,
		.next_pattern_enable, .latch_wr_en, .latch_wr_data,
		.port_output_latch, .group_trigger_select, .group_output_mode);
	potm_timer_model i_potm_timer_model (.aclk, .aresetn, .go(tgo),
		.pat(tpat), .cm(timer_match));

	////////////////////////////////////////////////////////////////////
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			final_report();
		end
	end

	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
			fail_count++;
		end
	endtask : chk

	task axw(input logic [7:0] a, input logic [31:0] d);
		bit ga, gw;
		ga = 0;
		gw = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(ga && gw)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				ga = 1;
				s_axi_awvalid <= 0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				gw = 1;
				s_axi_wvalid <= 0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 0;
		chk(32'(s_axi_bresp), 32'(RESP_OKAY));
		@(posedge aclk);
	endtask : axw

	task axr(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 0;
		@(posedge aclk);
	endtask : axr

	function automatic logic [15:0] nxt(logic [15:0] l, logic [7:0] s,
		logic [3:0] m, int ch, bit isb);
		logic [15:0] r;
		r = l;
		for (int i = 0; i < 16; i++)
			if (s[2*(i/4)+:2] == ch && next_pattern_enable[i] &&
				(!isb || (m[i/4] && !next_pattern_reg[i])))
				r[i] = next_pattern_reg[i];
		return r;
	endfunction : nxt

	task fire(input int ch, input bit isb);
		tgo <= 1;
		tpat.a <= isb ? 4'h0 : 4'(1 << ch);
		tpat.b <= isb ? 4'(1 << ch) : 4'h0;
		@(posedge aclk);
		tgo <= 0;
		repeat (2) @(posedge aclk);
	endtask : fire

	////////////////////////////////////////////////////////////////////
	task test_regs;
		axr(TRIG_SEL_OFS);
		chk(rd, 32'h000000ff);
		axr(OUT_MODE_OFS);
		chk(rd, 32'h000000f0);
		axw(OUT_MODE_OFS, 32'h0000000f);
		axr(OUT_MODE_OFS);
		chk(rd, 32'h000000ff);
		axw(OUT_MODE_OFS, 32'h00000000);
		chk(32'(group_output_mode), 32'h000000f0);
		axr(8'h08);
		chk(32'(rr), 32'(RESP_SLVERR));
		$display("test regs done");
	endtask : test_regs

	task test_trig;
		logic [7:0] s;
		logic [3:0] m;
		for (int k = 0; k < 2; k++) begin
			s = k ? 8'h1b : 8'he4;
			m = k ? 4'ha : 4'h5;
			axw(TRIG_SEL_OFS, 32'(s));
			axw(OUT_MODE_OFS, 32'(m));
			axr(TRIG_SEL_OFS);
			chk(rd, 32'(s));
			for (int ch = 0; ch < 4; ch++) begin
				next_pattern_enable <= 16'hf7ef;
				next_pattern_reg <= {4{4'(ch * 5 + k * 3 + 1)}} ^ 16'h0ff0;
				fire(ch, 0);
				exp_lat = nxt(exp_lat, s, m, ch, 0);
				chk(32'(port_output_latch), 32'(exp_lat));
				next_pattern_reg <= ~next_pattern_reg;
				fire(ch, 1);
				exp_lat = nxt(exp_lat, s, m, ch, 1);
				chk(32'(port_output_latch), 32'(exp_lat));
			end
		end
		$display("test trig done");
	endtask : test_trig

	task test_standby;
		hw_standby <= 1;
		@(posedge aclk);
		hw_standby <= 0;
		@(posedge aclk);
		chk(32'(group_trigger_select), 32'h000000ff);
		chk(32'(group_output_mode), 32'h000000f0);
		chk(32'(port_output_latch), 32'(LATCH_RST));
		$display("test standby done");
	endtask : test_standby

	// Neighbour write reaches only bits not owned by pattern output
	task test_nbr;
		next_pattern_enable <= 16'h00ff;
		latch_wr_data <= 16'hffff;
		latch_wr_en <= 1;
		@(posedge aclk);
		latch_wr_en <= 0;
		@(posedge aclk);
		chk(32'(port_output_latch), 32'h0000ff00);
		$display("test nbr done");
	endtask : test_nbr

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		test_regs();
		test_trig();
		test_standby();
		test_nbr();
		final_report();
	end
endmodule : test_potm_trigger_ctrl
